// ===== design/pipe_ctl_pkg.sv
// Purpose: shared types and constants for the pipeline interlock and exception controller
// Assumes: five stages, one clock
// Notes: cause codes are local encodings
package pipe_ctl_pkg;
	localparam int reg_addr_w = 5;
	localparam int cause_w = 5;
	localparam int vec_w = 32;
	// ====================
	// reset values and counts
	localparam logic [vec_w-1:0] reset_vector = 32'hbfc00000;
	localparam logic [vec_w-1:0] general_vector = 32'h80000180;
	localparam logic [1:0] load_dc_cycles = 2'h2;
	localparam logic [1:0] store_dc_cycles = 2'h2;
	localparam logic [1:0] one_slip_cycles = 2'h1;
	// ====================
	// exception cause codes, priority order within each stage
	typedef enum logic [cause_w-1:0] {
		ex_none = 5'h00,
		ex_fetch_address_error = 5'h01,
		ex_nmi = 5'h02,
		ex_instr_translation_fault = 5'h03,
		ex_external_interrupt = 5'h04,
		ex_instr_bus_error = 5'h05,
		ex_syscall = 5'h06,
		ex_breakpoint = 5'h07,
		ex_coprocessor_unusable = 5'h08,
		ex_reserved_instruction = 5'h09,
		ex_trap = 5'h0a,
		ex_integer_overflow = 5'h0b,
		ex_data_address_error = 5'h0c,
		ex_reset = 5'h0d,
		ex_data_translation_fault = 5'h0e,
		ex_page_modified_fault = 5'h0f,
		ex_watch_match = 5'h10,
		ex_data_bus_error = 5'h11
	} cause_t;
	// ====================
	// per-stage instruction descriptor from the datapath
	typedef struct packed {
		logic valid;
		logic is_load;
		logic is_store;
		logic is_mf_hilo;
		logic is_mf_sys;
		logic is_mt_sys_cfg;
		logic is_cache_op;
		logic uses_src_a;
		logic uses_src_b;
		logic writes_dst;
		logic [reg_addr_w-1:0] src_a;
		logic [reg_addr_w-1:0] src_b;
		logic [reg_addr_w-1:0] dst;
	} instr_t;
	// ====================
	// fault inputs
	typedef struct packed {
		logic fetch_address_error;
		logic nmi;
		logic instr_translation_fault;
		logic external_interrupt;
		logic instr_bus_error;
		logic syscall;
		logic breakpoint;
		logic coprocessor_unusable;
		logic reserved_instruction;
		logic trap;
		logic integer_overflow;
		logic data_address_error;
		logic reset_req;
		logic data_translation_fault;
		logic page_modified_fault;
		logic watch_match;
		logic data_bus_error;
	} fault_t;
	typedef struct packed {
		logic instr_translation_miss;
		logic instr_cache_miss;
		logic data_translation_miss;
		logic data_cache_miss;
		logic victim_dirty;
		logic refill_last_word;
		logic data_cache_busy;
		logic cache_op_done;
		logic muldiv_busy;
	} mem_status_t;
	// bypass selects: 0 regfile, 1 ex, 2 dc, 3 wb
	typedef enum logic [1:0] {
		byp_regfile = 2'h0,
		byp_ex = 2'h1,
		byp_dc = 2'h2,
		byp_wb = 2'h3
	} byp_t;
	typedef struct packed {
		logic [reg_addr_w-1:0] rd_addr_a;
		logic [reg_addr_w-1:0] rd_addr_b;
		logic [reg_addr_w-1:0] wr_addr;
		logic wr_en;
		byp_t sel_a;
		byp_t sel_b;
	} bypass_t;
	typedef struct packed {
		logic take;
		cause_t cause;
		logic [vec_w-1:0] vector;
	} commit_t;
	typedef enum logic [2:0] {
		st_run = 3'b001,
		st_miss = 3'b010,
		st_writeback = 3'b100
	} dc_state_t;
endpackage : pipe_ctl_pkg

// ===== design/pipe_ctl.sv
// Purpose: interlock, exception and bypass control for a five-stage pipeline
// Assumes: datapath holds stage registers and obeys stall, slip and kill
// Notes: stall freezes all stages; slip holds fetch, rf and ex, inserts a bubble into dc
`timescale 1ns/1ns
// How it works
// - check every occupied stage each cycle
// - each fault belongs to one stage
// - fixed per-stage exception lists, priority ordered
// - late misses stall whole pipe until resolved
// - exception kills it and younger; suppress their faults
// - commit at write back, vector pc, clear
// - precise: older finish, younger never
// - older later exception kills flagged younger one
// - dirty victim to write buffer; restart on last word
// - cache op in dc stalls until done
// - issue only with operands and resources ready
// - back end advances, bubbles behind slip
// - killed instructions never slip
// - load/move data hazard slips in register fetch
// - muldiv busy slips move from product registers
// - store then load slips rf one clock
// - config/status move slips rf one clock
// - forward ex, dc, wb results into ex
// - bypass logic drives register file addresses
// - load holds dc stage two cycles
// - store in dc slips ex behind it; no two-cycle count for store
module pipe_ctl (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// stage descriptors: if, rf, ex, dc, wb
	input pipe_ctl_pkg::instr_t st_if,
	input pipe_ctl_pkg::instr_t st_rf,
	input pipe_ctl_pkg::instr_t st_ex,
	input pipe_ctl_pkg::instr_t st_dc,
	input pipe_ctl_pkg::instr_t st_wb,
	// fault and memory status
	input pipe_ctl_pkg::fault_t faults,
	input pipe_ctl_pkg::mem_status_t mem,
	input wire logic branch_likely_kill,
	input wire logic eret_kill,
	// pipeline control
	output logic stall,
	output logic slip,
	output logic [4:0] kill,
	output logic move_to_write_buffer,
	// register file and bypass
	output pipe_ctl_pkg::bypass_t bypass,
	// exception commit
	output pipe_ctl_pkg::commit_t commit
);
	import pipe_ctl_pkg::*;
	// stage indices
	localparam int s_if = 0;
	localparam int s_rf = 1;
	localparam int s_ex = 2;
	localparam int s_dc = 3;
	localparam int s_wb = 4;

	// ====================
	// exception pending per stage, travels with instruction
	cause_t exc_reg [5];
	logic [4:0] dead_reg;
	cause_t det_if, det_rf, det_ex, det_dc;
	logic [4:0] killed;
	logic [4:0] live;
	dc_state_t dc_state_reg, dc_state_next;
	logic [1:0] dc_cnt_reg;
	logic [1:0] slip_cnt_reg;
	logic stall_c, slip_c, take_c;
	logic load_hazard, muldiv_hazard, st_ld_hazard, sys_hazard, dc_occupied;
	logic [1:0] rf_byp_a, rf_byp_b;

	assign take_c = (exc_reg[s_wb] != ex_none) && st_wb.valid && !dead_reg[s_wb];
	assign killed[s_if] = dead_reg[s_if] || branch_likely_kill || eret_kill;
	assign killed[s_rf] = dead_reg[s_rf] || branch_likely_kill || eret_kill;
	assign killed[s_ex] = dead_reg[s_ex];
	assign killed[s_dc] = dead_reg[s_dc];
	assign killed[s_wb] = dead_reg[s_wb];
	// live = occupied and not cancelled; faults of dead ones are ignored
	assign live = {st_wb.valid, st_dc.valid, st_ex.valid, st_rf.valid, st_if.valid} &
		~killed & ~{5{take_c}};

	// ====================
	// per-stage exception detection, priority order
	always_comb begin
		det_if = ex_none;
		if (faults.fetch_address_error) det_if = ex_fetch_address_error;
	end
	always_comb begin
		det_rf = ex_none;
		if (faults.nmi) det_rf = ex_nmi;
		else if (faults.instr_translation_fault) det_rf = ex_instr_translation_fault;
		else if (faults.external_interrupt) det_rf = ex_external_interrupt;
		else if (faults.instr_bus_error) det_rf = ex_instr_bus_error;
		else if (faults.syscall) det_rf = ex_syscall;
		else if (faults.breakpoint) det_rf = ex_breakpoint;
		else if (faults.coprocessor_unusable) det_rf = ex_coprocessor_unusable;
		else if (faults.reserved_instruction) det_rf = ex_reserved_instruction;
	end
	always_comb begin
		det_ex = ex_none;
		if (faults.trap) det_ex = ex_trap;
		else if (faults.integer_overflow) det_ex = ex_integer_overflow;
		else if (faults.data_address_error) det_ex = ex_data_address_error;
	end
	always_comb begin
		det_dc = ex_none;
		if (faults.reset_req) det_dc = ex_reset;
		else if (faults.data_translation_fault) det_dc = ex_data_translation_fault;
		else if (faults.page_modified_fault) det_dc = ex_page_modified_fault;
		else if (faults.watch_match) det_dc = ex_watch_match;
		else if (faults.data_bus_error) det_dc = ex_data_bus_error;
	end

	// ====================
	// stall: conditions from the data cache stage and instruction fetch misses
	always_comb begin
		dc_state_next = dc_state_reg;
		unique case (dc_state_reg)
			st_run: begin
				if (live[s_dc] && mem.data_cache_miss && mem.victim_dirty)
					dc_state_next = st_writeback;
				else if (live[s_dc] && mem.data_cache_miss)
					dc_state_next = st_miss;
			end
			st_writeback: dc_state_next = st_miss;
			st_miss: begin
				if (mem.refill_last_word) dc_state_next = st_run;
			end
		endcase
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dc_state_reg <= st_run;
		end else begin
			dc_state_reg <= dc_state_next;
		end
	end

	// load and store in dc slip ex; only a load starts the two-cycle dc countdown
	assign dc_occupied = live[s_dc] && (st_dc.is_load || st_dc.is_store) &&
		(dc_cnt_reg == 2'h0);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dc_cnt_reg <= 2'h0;
		end else if (!stall_c && dc_cnt_reg != 2'h0) begin
			dc_cnt_reg <= dc_cnt_reg - 2'h1;
		end else if (!stall_c && live[s_dc] && st_dc.is_load && dc_cnt_reg == 2'h0) begin
			dc_cnt_reg <= load_dc_cycles - 2'h1;
		end
	end

	always_comb begin
		stall_c = 1'b0;
		if (live[s_rf] && (mem.instr_translation_miss || mem.instr_cache_miss))
			stall_c = 1'b1;
		if (live[s_dc] && (mem.data_translation_miss || mem.data_cache_miss ||
			mem.data_cache_busy))
			stall_c = 1'b1;
		if (dc_state_reg != st_run && !mem.refill_last_word)
			stall_c = 1'b1;
		if (live[s_dc] && st_dc.is_cache_op && !mem.cache_op_done)
			stall_c = 1'b1;
		if (take_c) stall_c = 1'b0;
	end

	// ====================
	// slip hazards evaluated on live instructions only
	assign load_hazard = live[s_rf] && live[s_ex] && st_ex.writes_dst &&
		(st_ex.is_load || st_ex.is_mf_hilo || st_ex.is_mf_sys) &&
		((st_rf.uses_src_a && st_rf.src_a == st_ex.dst) ||
		(st_rf.uses_src_b && st_rf.src_b == st_ex.dst));
	assign muldiv_hazard = live[s_rf] && st_rf.is_mf_hilo && mem.muldiv_busy;
	assign st_ld_hazard = live[s_ex] && live[s_rf] && st_ex.is_store && st_rf.is_load &&
		slip_cnt_reg == 2'h0;
	assign sys_hazard = live[s_ex] && st_ex.is_mt_sys_cfg && slip_cnt_reg == 2'h0;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slip_cnt_reg <= 2'h0;
		end else if (!stall_c) begin
			if (slip_cnt_reg != 2'h0) slip_cnt_reg <= slip_cnt_reg - 2'h1;
			else if (st_ld_hazard || sys_hazard) slip_cnt_reg <= one_slip_cycles;
		end
	end

	// issue only when operands and resources are ready
	assign slip_c = !stall_c && !take_c && (load_hazard || muldiv_hazard || st_ld_hazard ||
		sys_hazard || (dc_occupied && live[s_ex]));

	// ====================
	// exception pipeline: flags move with instructions, killed ones pick up no new flag
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 5; i++) exc_reg[i] <= ex_none;
			dead_reg <= 5'h00;
		end else if (take_c) begin
			for (int i = 0; i < 5; i++) exc_reg[i] <= ex_none;
			dead_reg <= 5'h00;
		end else if (!stall_c) begin
			// dc to wb always advances on a slip
			exc_reg[s_wb] <= (live[s_dc] && exc_reg[s_dc] == ex_none) ? det_dc : exc_reg[s_dc];
			dead_reg[s_wb] <= killed[s_dc];
			if (slip_c) begin
				exc_reg[s_dc] <= ex_none;
				dead_reg[s_dc] <= 1'b1;
			end else begin
				exc_reg[s_dc] <= (live[s_ex] && exc_reg[s_ex] == ex_none) ? det_ex : exc_reg[s_ex];
				exc_reg[s_ex] <= (live[s_rf] && exc_reg[s_rf] == ex_none) ? det_rf : exc_reg[s_rf];
				exc_reg[s_rf] <= (live[s_if] && exc_reg[s_if] == ex_none) ? det_if : exc_reg[s_if];
				exc_reg[s_if] <= ex_none;
				dead_reg[s_dc] <= killed[s_ex];
				dead_reg[s_ex] <= killed[s_rf];
				dead_reg[s_rf] <= killed[s_if];
				dead_reg[s_if] <= 1'b0;
			end
		end
	end

	// ====================
	// bypass and register file addressing
	function automatic logic [1:0] pick(input logic [reg_addr_w-1:0] r);
		logic [1:0] s;
		s = byp_regfile;
		if (r != '0 && st_wb.valid && st_wb.writes_dst && st_wb.dst == r) s = byp_wb;
		if (r != '0 && st_dc.valid && st_dc.writes_dst && st_dc.dst == r) s = byp_dc;
		if (r != '0 && st_ex.valid && st_ex.writes_dst && st_ex.dst == r) s = byp_ex;
		return s;
	endfunction
	assign rf_byp_a = pick(st_rf.src_a);
	assign rf_byp_b = pick(st_rf.src_b);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bypass <= '0;
		end else begin
			bypass.rd_addr_a <= st_if.src_a;
			bypass.rd_addr_b <= st_if.src_b;
			bypass.wr_addr <= st_dc.dst;
			bypass.wr_en <= live[s_dc] && st_dc.writes_dst && !stall_c &&
				(exc_reg[s_dc] == ex_none) && (det_dc == ex_none);
			bypass.sel_a <= byp_t'(rf_byp_a);
			bypass.sel_b <= byp_t'(rf_byp_b);
		end
	end

	// ====================
	// pipeline control outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stall <= 1'b0;
			slip <= 1'b0;
			kill <= 5'h00;
			move_to_write_buffer <= 1'b0;
		end else begin
			stall <= stall_c;
			slip <= slip_c;
			kill <= take_c ? 5'h1f : (killed & ~{5{stall_c}});
			move_to_write_buffer <= (dc_state_reg == st_run) && (dc_state_next == st_writeback);
		end
	end

	// ====================
	// exception commit at write back
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			commit <= '0;
		end else begin
			commit.take <= take_c;
			commit.cause <= take_c ? exc_reg[s_wb] : ex_none;
			commit.vector <= !take_c ? '0 :
				(exc_reg[s_wb] == ex_reset ? reset_vector : general_vector);
		end
	end
endmodule // pipe_ctl

// ===== test/pipe_ctl_monitor.sv
// Purpose: concurrent checks on the pipeline controller ports
// Assumes: every output is registered one cycle after its inputs
// Notes: bound to the controller from the testbench
`timescale 1ns/1ns
module pipe_ctl_monitor import pipe_ctl_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// stage descriptors and status
	input pipe_ctl_pkg::instr_t st_if,
	input pipe_ctl_pkg::instr_t st_rf,
	input pipe_ctl_pkg::instr_t st_ex,
	input pipe_ctl_pkg::instr_t st_dc,
	input pipe_ctl_pkg::instr_t st_wb,
	input pipe_ctl_pkg::fault_t faults,
	input pipe_ctl_pkg::mem_status_t mem,
	input wire logic branch_likely_kill,
	input wire logic eret_kill,
	// controller outputs
	input wire logic stall,
	input wire logic slip,
	input wire logic [4:0] kill,
	input wire logic move_to_write_buffer,
	input pipe_ctl_pkg::bypass_t bypass,
	input pipe_ctl_pkg::commit_t commit
);
	logic quiet;
	logic load_hz;
	assign quiet = (faults == '0) && !branch_likely_kill && !eret_kill && !commit.take && (kill == 5'h00);
	assign load_hz = st_rf.valid && st_ex.valid && st_ex.is_load && st_ex.writes_dst
		&& st_rf.uses_src_a && (st_rf.src_a == st_ex.dst);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ====================
	// sequences
	sequence dirty_miss_s;
		$rose(mem.data_cache_miss) && mem.victim_dirty && st_dc.valid && quiet;
	endsequence
	sequence dc_fault_s;
		st_dc.valid && faults.data_bus_error && quiet && !stall;
	endsequence
	// ====================
	// assertions
	miss_stalls_a: assert property (st_dc.valid && mem.data_cache_miss && !mem.refill_last_word && quiet |=> stall)
		else $error("data miss without stall");
	cacheop_stall_a: assert property (st_dc.valid && st_dc.is_cache_op && !mem.cache_op_done && quiet |=> stall)
		else $error("cache op without stall");
	victim_move_a: assert property (dirty_miss_s |-> ##[1:2] move_to_write_buffer)
		else $error("dirty victim not moved");
	move_pulse_a: assert property (move_to_write_buffer |=> !move_to_write_buffer)
		else $error("move pulse too long");
	refill_restart_a: assert property (stall && mem.refill_last_word |-> ##[1:2] !stall)
		else $error("no restart after refill");
	load_slip_a: assert property (load_hz && quiet && (mem == '0) && !stall |=> slip)
		else $error("load hazard without slip");
	killed_noslip_a: assert property (load_hz && eret_kill && (mem == '0) && !stall |=> !slip)
		else $error("killed instruction slipped");
	stall_wins_a: assert property (stall |-> !slip)
		else $error("slip during stall");
	dc_commit_a: assert property (dc_fault_s |-> ##[1:2] commit.take)
		else $error("dc fault not committed");
	take_vector_a: assert property (commit.take && (commit.cause != ex_reset) |-> commit.vector == general_vector)
		else $error("wrong exception vector");
	take_kill_a: assert property (commit.take |-> ##[0:1] (kill == 5'h1f))
		else $error("younger stages not killed");
endmodule // pipe_ctl_monitor

// ===== test/mem_side_model.sv
// Purpose: behavioural cache refill, cache op and multiply-divide side
// Assumes: each request starts a countdown of lat cycles
// Notes: translation misses and cache busy stay low
`timescale 1ns/1ns
module mem_side_model import pipe_ctl_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// requests from the bench
	input wire logic miss_go,
	input wire logic dirty,
	input wire logic op_go,
	input wire logic md_go,
	input wire logic [3:0] lat,
	// status towards the controller
	output pipe_ctl_pkg::mem_status_t mem
);
	logic [3:0] miss_cnt_reg;
	logic [3:0] op_cnt_reg;
	logic [3:0] md_cnt_reg;
	logic dirty_reg;
	// ====================
	// countdowns
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			miss_cnt_reg <= 4'h0;
			dirty_reg <= 1'b0;
		end else begin
			miss_cnt_reg <= miss_go ? lat : miss_cnt_reg - {3'h0, miss_cnt_reg != 4'h0};
			dirty_reg <= miss_go ? dirty : dirty_reg;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			op_cnt_reg <= 4'h0;
		end else begin
			op_cnt_reg <= op_go ? lat : op_cnt_reg - {3'h0, op_cnt_reg != 4'h0};
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			md_cnt_reg <= 4'h0;
		end else begin
			md_cnt_reg <= md_go ? lat : md_cnt_reg - {3'h0, md_cnt_reg != 4'h0};
		end
	end
	always_comb begin
		mem = '0;
		mem.data_cache_miss = miss_cnt_reg != 4'h0;
		mem.victim_dirty = dirty_reg && (miss_cnt_reg != 4'h0);
		mem.refill_last_word = miss_cnt_reg == 4'h1;
		mem.cache_op_done = op_cnt_reg == 4'h1;
		mem.muldiv_busy = md_cnt_reg != 4'h0;
	end
endmodule // mem_side_model

// ===== test/testbench.sv
// Purpose: self-checking bench for the interlock and exception controller
// Assumes: outputs registered one cycle after the inputs
// Notes: stage descriptors are held by the bench, not advanced
`timescale 1ns/1ns
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module testbench;
	import pipe_ctl_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	instr_t st_if, st_rf, st_ex, st_dc, st_wb;
	fault_t faults;
	mem_status_t mem;
	logic branch_likely_kill, eret_kill, stall, slip, move_to_write_buffer;
	logic [4:0] kill;
	bypass_t bypass;
	commit_t commit;
	logic miss_go, dirty, op_go, md_go;
	logic [3:0] lat;
	int mismatches = 0;
	int num_checks = 0;
	always #20 clk = ~clk;
	pipe_ctl i_dut (.clk(clk), .rst_b(rst_b), .st_if(st_if), .st_rf(st_rf), .st_ex(st_ex),
		.st_dc(st_dc), .st_wb(st_wb), .faults(faults), .mem(mem),
		.branch_likely_kill(branch_likely_kill), .eret_kill(eret_kill), .stall(stall),
		.slip(slip), .kill(kill), .move_to_write_buffer(move_to_write_buffer),
		.bypass(bypass), .commit(commit));
	mem_side_model i_mem (.clk(clk), .rst_b(rst_b), .miss_go(miss_go), .dirty(dirty),
		.op_go(op_go), .md_go(md_go), .lat(lat), .mem(mem));
	// ====================
	// helpers
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic idle();
		{st_if, st_rf, st_ex, st_dc, st_wb} = '0;
		faults = '0;
		{branch_likely_kill, eret_kill, miss_go, dirty, op_go, md_go} = '0;
		lat = 4'h4;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ====================
	// scenarios
	task automatic t_dc_miss();
		int ns;
		int nm;
		ns = 0;
		nm = 0;
		st_dc = '{valid: 1'b1, is_load: 1'b1, default: '0};
		dirty = 1'b1;
		miss_go = 1'b1;
		step(1);
		miss_go = 1'b0;
		repeat (10) begin
			step(1);
			ns += stall;
			nm += move_to_write_buffer;
			if (mem.refill_last_word) st_dc = '0;
		end
		`CHK(nm, 1)
		`CHK(ns inside {[3:6]}, 1'b1)
		`CHK(stall, 1'b0)
	endtask
	task automatic t_cache_op();
		int ns;
		ns = 0;
		st_dc = '{valid: 1'b1, is_cache_op: 1'b1, default: '0};
		op_go = 1'b1;
		step(1);
		op_go = 1'b0;
		repeat (8) begin
			step(1);
			ns += stall;
			if (mem.cache_op_done) st_dc = '0;
		end
		`CHK(ns inside {[2:5]}, 1'b1)
		`CHK(stall, 1'b0)
	endtask
	task automatic t_load_use();
		st_if = '{valid: 1'b1, uses_src_a: 1'b1, src_a: 5'h09, default: '0};
		st_rf = '{valid: 1'b1, uses_src_a: 1'b1, src_a: 5'h06, default: '0};
		st_ex = '{valid: 1'b1, is_load: 1'b1, writes_dst: 1'b1, dst: 5'h05, default: '0};
		st_dc = '{valid: 1'b1, writes_dst: 1'b1, dst: 5'h07, default: '0};
		step(1);
		`CHK(slip, 1'b0)
		`CHK(bypass.wr_addr, 5'h07)
		st_rf.src_a = 5'h05;
		step(1);
		`CHK(slip, 1'b1)
		`CHK(bypass.rd_addr_a, 5'h09)
		`CHK(bypass.sel_a, byp_ex)
		`CHK(bypass.wr_en, 1'b1)
		eret_kill = 1'b1;
		step(1);
		`CHK(slip, 1'b0)
		idle();
		step(2);
	endtask
	task automatic t_muldiv();
		int n;
		n = 0;
		st_rf = '{valid: 1'b1, is_mf_hilo: 1'b1, default: '0};
		lat = 4'h3;
		md_go = 1'b1;
		step(1);
		md_go = 1'b0;
		repeat (8) begin
			step(1);
			n += slip;
		end
		`CHK(n inside {[2:4]}, 1'b1)
		`CHK(slip, 1'b0)
		idle();
		step(2);
	endtask
	task automatic t_stall_over_slip();
		int nb;
		int ns;
		nb = 0;
		ns = 0;
		st_dc = '{valid: 1'b1, is_load: 1'b1, default: '0};
		miss_go = 1'b1;
		step(1);
		miss_go = 1'b0;
		st_rf = '{valid: 1'b1, uses_src_a: 1'b1, src_a: 5'h05, default: '0};
		st_ex = '{valid: 1'b1, is_load: 1'b1, writes_dst: 1'b1, dst: 5'h05, default: '0};
		repeat (4) begin
			step(1);
			nb += stall && slip;
			ns += stall;
		end
		`CHK(nb, 0)
		`CHK(ns > 0, 1'b1)
		idle();
		step(6);
	endtask
	task automatic t_fault(input fault_t f, input cause_t exp);
		int extra;
		int k;
		extra = 0;
		{st_if.valid, st_rf.valid, st_ex.valid, st_dc.valid, st_wb.valid} = 5'h1f;
		faults = f;
		step(1);
		faults = '0;
		for (k = 0; k < 10 && commit.take !== 1'b1; k++) step(1);
		`CHK(commit.take, 1'b1)
		`CHK(commit.cause, exp)
		`CHK(commit.vector, (exp == ex_reset) ? reset_vector : general_vector)
		`CHK(kill, 5'h1f)
		step(1);
		repeat (8) begin
			step(1);
			extra += commit.take;
		end
		`CHK(extra, 0)
		idle();
		step(2);
	endtask
	task automatic t_order();
		fault_t f;
		f = '0;
		f.nmi = 1'b1;
		f.data_bus_error = 1'b1;
		t_fault(f, ex_data_bus_error);
		f.reset_req = 1'b1;
		t_fault(f, ex_reset);
	endtask
	// ====================
	// main sequence
	initial begin
		idle();
		step(3);
		`CHK(commit.take, 1'b0)
		`CHK(kill, 5'h00)
		rst_b = 1'b1;
		step(2);
		t_dc_miss();
		t_cache_op();
		t_load_use();
		t_muldiv();
		t_stall_over_slip();
		for (int i = 0; i < 17; i++) t_fault(fault_t'(17'h1 << (16 - i)), cause_t'(i + 1));
		t_order();
		summarize();
	end
	initial begin
		#(40 * 4000);
		mismatches++;
		summarize();
	end
endmodule // testbench
bind pipe_ctl pipe_ctl_monitor i_mon (.clk(clk), .rst_b(rst_b), .st_if(st_if), .st_rf(st_rf),
	.st_ex(st_ex), .st_dc(st_dc), .st_wb(st_wb), .faults(faults), .mem(mem),
	.branch_likely_kill(branch_likely_kill), .eret_kill(eret_kill), .stall(stall),
	.slip(slip), .kill(kill), .move_to_write_buffer(move_to_write_buffer),
	.bypass(bypass), .commit(commit));
